//--- inc/irq_vec_pkg.sv
// How it works
// (R1) When several requests are pending at once, the one with the highest fixed priority is granted first.
// (R2) A reset request is the top-priority interrupt and branches to 0xFFFE.
// (R3) An external break request raises a priority-2 interrupt that enters emulator mode and branches to 0x0002.
// (R4) A software debug trap raises a priority-2 interrupt that also enters emulator mode at the break address.
// (R5) The break and trap branch address lies in the memory region kept for debug instructions.
// (R6) An overflow that sets the first overflow flag raises a priority-3 interrupt branching to 0xFFFC.
// (R7) An overflow that sets the third overflow flag raises a priority-4 interrupt branching to 0xFFFA.
// (R8) The four DMA request lines are priorities 5 to 8 in index order and carry no branch address.
// (R9) The peripheral interrupt input is priority 9 and branches to 0xFFF8.
// (R10) External lines one to seven are priorities 10 to 16 with addresses falling by two from 0xFFF6 to 0xFFEA.
// (R11) While a program download is in progress every request except reset is ignored.
// (R12) Outside a download, each request stays pending until its grant is acknowledged, so lower priorities are served later.
// (R13) Request sources hold their inputs for at least one clock cycle so that they are sampled.
package irq_vec_pkg;

	// ==========================================================
	// Request numbering
	// ==========================================================
	localparam int NUM_SRC = 17;

	localparam int SRC_RESET = 0;
	localparam int SRC_BREAK = 1;
	localparam int SRC_TRAP = 2;
	localparam int SRC_OVF1 = 3;
	localparam int SRC_OVF3 = 4;
	localparam int SRC_DMA_REQUEST_ZERO = 5;
	localparam int SRC_EXT0 = 9;
	localparam int SRC_EXT1 = 10;

	// ==========================================================
	// Branch addresses
	// ==========================================================
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_DEBUG = 16'h0002;
	localparam logic [15:0] VEC_OVF1 = 16'hfffc;
	localparam logic [15:0] VEC_OVF3 = 16'hfffa;
	localparam logic [15:0] VEC_EXT0 = 16'hfff8;
	localparam logic [15:0] VEC_EXT1 = 16'hfff6;
	localparam logic [15:0] VEC_STEP = 16'h0002;
	localparam logic [15:0] VEC_NONE = 16'h0000;

	localparam logic [16:0] PEND_RESET_VAL = 17'h0_0000;

	typedef struct packed {
		logic       valid;
		logic [4:0] priority_level;
		logic [4:0] source;
		logic [15:0] vector;
		logic       has_vector;
		logic       emulator;
	} grant_t;

endpackage

//--- hdl/irq_prio_pick.sv
`timescale 1ns/10ps
module irq_prio_pick
	import irq_vec_pkg::*;
(
	input  wire logic [NUM_SRC-1:0] pend_in,
	output logic                    any_out,
	output logic [4:0]              index_out
);

	// Lowest index is the highest priority.
	always_comb begin
		any_out = 1'b0;
		index_out = 5'd0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pend_in[i]) begin
				any_out = 1'b1; // R1
				index_out = 5'(i);
			end
		end
	end

endmodule

//--- hdl/dsp_interrupt_priority_vectoring.sv
`timescale 1ns/10ps
module dsp_interrupt_priority_vectoring
	import irq_vec_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       reset_req_in,
	input  wire logic       break_req_in,
	input  wire logic       trap_exec_in,
	input  wire logic       overflow_flag_one_in,
	input  wire logic       overflow_flag_three_in,
	input  wire logic [3:0] dma_request_in,
	input  wire logic       peripheral_irq_source_in,
	input  wire logic [7:1] ext_request_in,
	input  wire logic       download_active_in,
	input  wire logic       grant_ack_in,
	output logic            grant_valid_out,
	output logic [4:0]      grant_priority_out,
	output logic [4:0]      grant_source_out,
	output logic [15:0]     grant_vector_out,
	output logic            grant_has_vector_out,
	output logic            emulator_entry_out,
	output logic [16:0]     pending_out
);

	// ==========================================================
	// Request capture
	// ==========================================================
	logic [NUM_SRC-1:0] raw_req;
	logic [NUM_SRC-1:0] pend_q;
	logic [NUM_SRC-1:0] pend_d;
	logic [NUM_SRC-1:0] eff_pend;
	logic               pick_any;
	logic [4:0]         pick_idx;
	grant_t             grant_q;
	grant_t             grant_d;

	always_comb begin
		raw_req = '0;
		raw_req[SRC_RESET] = reset_req_in; // R2
		raw_req[SRC_BREAK] = break_req_in; // R3
		raw_req[SRC_TRAP] = trap_exec_in; // R4
		raw_req[SRC_OVF1] = overflow_flag_one_in; // R6
		raw_req[SRC_OVF3] = overflow_flag_three_in; // R7
		raw_req[SRC_DMA_REQUEST_ZERO +: 4] = dma_request_in; // R8
		raw_req[SRC_EXT0] = peripheral_irq_source_in; // R9
		raw_req[SRC_EXT1 +: 7] = ext_request_in; // R10
	end

	// Requests are sampled every cycle, so a one-cycle pulse is enough.
	always_comb begin
		pend_d = pend_q | raw_req; // R13
		// A new request in the cycle of its grant's acknowledge stays pending.
		if (grant_q.valid && grant_ack_in) begin
			pend_d[grant_q.source] = raw_req[grant_q.source]; // R12
		end
		// Download blocks everything except reset; blocked requests are dropped, not held.
		// The mask comes last so that a re-request in an acknowledge cycle cannot slip past it.
		if (download_active_in) begin
			pend_d = pend_d & (NUM_SRC'(1) << SRC_RESET); // R11
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pend_q <= PEND_RESET_VAL;
		end else begin
			pend_q <= pend_d;
		end
	end

	// ==========================================================
	// Priority selection and vectoring
	// ==========================================================
	assign eff_pend = download_active_in ? (pend_q & (NUM_SRC'(1) << SRC_RESET)) : pend_q;

	irq_prio_pick u_pick (
		.pend_in   (eff_pend),
		.any_out   (pick_any),
		.index_out (pick_idx)
	);

	// ==========================================================
	// Per-source priority and branch address
	// ==========================================================
	// One entry per source keeps every level and address in plain view, at the cost of length.
	logic [4:0]  pick_level;
	logic [15:0] pick_vector;
	logic        pick_has_vector;
	logic        pick_emulator;

	always_comb begin
		pick_level = 5'd0;
		pick_vector = VEC_NONE;
		pick_has_vector = 1'b1;
		pick_emulator = 1'b0;
		unique case (pick_idx)
			5'(SRC_RESET): begin
				pick_level = 5'd1;
				pick_vector = VEC_RESET; // R2
			end
			5'(SRC_BREAK): begin
				pick_level = 5'd2;
				pick_vector = VEC_DEBUG; // R5
				pick_emulator = 1'b1; // R3
			end
			5'(SRC_TRAP): begin
				pick_level = 5'd2;
				pick_vector = VEC_DEBUG; // R5
				pick_emulator = 1'b1; // R4
			end
			5'(SRC_OVF1): begin
				pick_level = 5'(SRC_OVF1);
				pick_vector = VEC_OVF1; // R6
			end
			5'(SRC_OVF3): begin
				pick_level = 5'(SRC_OVF3);
				pick_vector = VEC_OVF3; // R7
			end
			// DMA requests are served by priority alone; the core finds no branch address.
			5'(SRC_DMA_REQUEST_ZERO): begin
				pick_level = 5'(SRC_DMA_REQUEST_ZERO);
				pick_has_vector = 1'b0; // R8
			end
			5'(SRC_DMA_REQUEST_ZERO + 1): begin
				pick_level = 5'(SRC_DMA_REQUEST_ZERO + 1);
				pick_has_vector = 1'b0; // R8
			end
			5'(SRC_DMA_REQUEST_ZERO + 2): begin
				pick_level = 5'(SRC_DMA_REQUEST_ZERO + 2);
				pick_has_vector = 1'b0; // R8
			end
			5'(SRC_DMA_REQUEST_ZERO + 3): begin
				pick_level = 5'(SRC_DMA_REQUEST_ZERO + 3);
				pick_has_vector = 1'b0; // R8
			end
			5'(SRC_EXT0): begin
				pick_level = 5'(SRC_EXT0);
				pick_vector = VEC_EXT0; // R9
			end
			// External lines step down by one branch slot per line.
			5'(SRC_EXT1): begin
				pick_level = 5'(SRC_EXT1);
				pick_vector = VEC_EXT1; // R10
			end
			5'(SRC_EXT1 + 1): begin
				pick_level = 5'(SRC_EXT1 + 1);
				pick_vector = VEC_EXT1 - VEC_STEP; // R10
			end
			5'(SRC_EXT1 + 2): begin
				pick_level = 5'(SRC_EXT1 + 2);
				pick_vector = VEC_EXT1 - VEC_STEP * 16'h0002; // R10
			end
			5'(SRC_EXT1 + 3): begin
				pick_level = 5'(SRC_EXT1 + 3);
				pick_vector = VEC_EXT1 - VEC_STEP * 16'h0003; // R10
			end
			5'(SRC_EXT1 + 4): begin
				pick_level = 5'(SRC_EXT1 + 4);
				pick_vector = VEC_EXT1 - VEC_STEP * 16'h0004; // R10
			end
			5'(SRC_EXT1 + 5): begin
				pick_level = 5'(SRC_EXT1 + 5);
				pick_vector = VEC_EXT1 - VEC_STEP * 16'h0005; // R10
			end
			5'(SRC_EXT1 + 6): begin
				pick_level = 5'(SRC_EXT1 + 6);
				pick_vector = VEC_EXT1 - VEC_STEP * 16'h0006; // R10
			end
			// Indices past the last external line never come out of the picker.
			default: begin
			end
		endcase
	end

	// The grant is held until acknowledged so the vector is stable, except that a
	// reset request always takes over at once and a download drops any other grant.
	always_comb begin
		grant_d = grant_q;
		if (grant_q.valid && grant_ack_in) begin
			grant_d.valid = 1'b0;
		end
		if ((!grant_d.valid || eff_pend[SRC_RESET]) && pick_any &&
		    !(grant_q.valid && grant_ack_in && grant_q.source == pick_idx &&
		      !raw_req[pick_idx])) begin
			grant_d.valid = 1'b1; // R1
			grant_d.source = pick_idx;
			grant_d.priority_level = pick_level;
			grant_d.vector = pick_vector;
			grant_d.has_vector = pick_has_vector;
			grant_d.emulator = pick_emulator; // R3 R4
		end
		if (download_active_in && grant_d.valid && grant_d.source != 5'(SRC_RESET)) begin
			grant_d.valid = 1'b0; // R11
		end
		// The emulator flag is kept only with a standing grant, so the output needs no gate.
		grant_d.emulator = grant_d.emulator & grant_d.valid;
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			grant_q <= '0;
		end else begin
			grant_q <= grant_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	always_comb begin
		grant_valid_out = grant_q.valid;
		grant_priority_out = grant_q.priority_level;
		grant_source_out = grant_q.source;
		grant_vector_out = grant_q.vector;
		grant_has_vector_out = grant_q.has_vector;
		emulator_entry_out = grant_q.emulator;
		pending_out = pend_q;
	end

endmodule

//--- verif/irq_src_model.sv
`timescale 1ns/10ps
// =====
// Request sources
module irq_src_model (
	input  wire logic [16:0] fire_in,
	output logic [16:0]      req_out
);
	// The bench changes fire_in only at falling edges, so every request spans a full cycle.
	assign req_out = fire_in;
endmodule

//--- verif/dsp_irq_properties.sv
`timescale 1ns/10ps
module dsp_irq_checker
	import irq_vec_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        sys_rst_in,
	input wire logic        reset_req_in,
	input wire logic        download_active_in,
	input wire logic        grant_ack_in,
	input wire logic        grant_valid_out,
	input wire logic [4:0]  grant_priority_out,
	input wire logic [4:0]  grant_source_out,
	input wire logic [15:0] grant_vector_out,
	input wire logic        grant_has_vector_out,
	input wire logic        emulator_entry_out,
	input wire logic [16:0] pending_out
);
	// =====
	// Grant checks
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_held;
		grant_valid_out && !grant_ack_in && !reset_req_in && !download_active_in &&
		(!pending_out[0] || grant_source_out == 5'd0);
	endsequence
	a_reset_vector: assert property (grant_valid_out && grant_source_out == 5'd0 |->
		grant_vector_out == 16'hfffe && grant_priority_out == 5'd1) else $error("reset grant");
	a_debug_entry: assert property (grant_valid_out && grant_source_out inside {5'd1, 5'd2} |->
		emulator_entry_out && grant_vector_out == 16'h0002 && grant_priority_out == 5'd2)
		else $error("debug grant");
	a_ovf_vector: assert property (grant_valid_out && grant_source_out inside {5'd3, 5'd4} |->
		16'(grant_vector_out + {grant_source_out, 1'b0}) == 16'h0002) else $error("ovf vector");
	a_dma_novector: assert property (grant_valid_out && grant_source_out inside {[5'd5:5'd8]} |->
		!grant_has_vector_out && grant_vector_out == 16'h0000) else $error("dma vector");
	a_ext_vector: assert property (grant_valid_out && grant_source_out > 5'd8 |->
		16'(grant_vector_out + {grant_source_out, 1'b0}) == 16'h000a) else $error("ext vector");
	a_level_match: assert property (grant_valid_out && grant_source_out > 5'd2 |->
		grant_priority_out == grant_source_out) else $error("priority level");
	a_top_wins: assert property ($rose(grant_valid_out) |->
		(pending_out & ((17'h1 << grant_source_out) - 17'h1)) == 17'h0) else $error("not top");
	a_download_mask: assert property ($past(download_active_in) && download_active_in |->
		!grant_valid_out || grant_source_out == 5'd0) else $error("download grant");
	a_grant_held: assert property (s_held |=> grant_valid_out && $stable(grant_source_out))
		else $error("grant lost");
endmodule
bind dsp_interrupt_priority_vectoring dsp_irq_checker u_dsp_irq_checker (.*);

//--- verif/dsp_interrupt_priority_vectoring_tb.sv
`timescale 1ns/10ps
module dsp_interrupt_priority_vectoring_tb;
	import irq_vec_pkg::*;
	logic        mclk_in = 1'b0, sys_rst_in = 1'b1, download_active_in = 1'b0, grant_ack_in = 1'b0;
	logic [16:0] fire = 17'h0_0000, req;
	logic        reset_req_in, break_req_in, trap_exec_in, overflow_flag_one_in;
	logic        overflow_flag_three_in, peripheral_irq_source_in, grant_valid_out;
	logic        grant_has_vector_out, emulator_entry_out;
	logic [3:0]  dma_request_in;
	logic [7:1]  ext_request_in;
	logic [4:0]  grant_priority_out, grant_source_out;
	logic [15:0] grant_vector_out;
	logic [16:0] pending_out;
	int          err_total = 0, n_compared = 0;
	always #25 mclk_in = ~mclk_in;
	assign {ext_request_in, peripheral_irq_source_in, dma_request_in, overflow_flag_three_in,
		overflow_flag_one_in, trap_exec_in, break_req_in, reset_req_in} = req;
	irq_src_model u_irq_src_model (.fire_in(fire), .req_out(req));
	dsp_interrupt_priority_vectoring u_dsp_interrupt_priority_vectoring (.*);
	task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic pulse(input logic [16:0] m);
		@(negedge mclk_in) fire = m;
		@(negedge mclk_in) fire = 17'h0_0000;
	endtask
	// Acks each standing grant until nothing is pending; an idle cycle follows every
	// acknowledge, and the bound keeps a stuck grant from hanging the run.
	task automatic drain();
		for (int k = 0; k < 40 && {pending_out, grant_valid_out} !== 18'h0_0000; k++) begin
			@(negedge mclk_in) grant_ack_in = grant_valid_out;
		end
		@(negedge mclk_in) grant_ack_in = 1'b0;
		chk(pending_out, 17'h0_0000);
		chk(grant_valid_out, 1'b0);
	endtask
	task automatic t_sysreset();
		pulse(17'h0_0400);
		@(negedge mclk_in) sys_rst_in = 1'b1;
		chk({grant_valid_out, grant_source_out}, {1'b1, 5'd10});
		@(negedge mclk_in) sys_rst_in = 1'b0;
		chk(pending_out, 17'h0_0000);
		chk(grant_valid_out, 1'b0);
	endtask
	task automatic t_preempt();
		pulse(17'h0_0020);
		@(negedge mclk_in);
		chk({grant_valid_out, grant_source_out}, {1'b1, 5'd5});
		pulse(17'h0_0001);
		@(negedge mclk_in);
		chk({grant_valid_out, grant_source_out}, {1'b1, 5'd0});
		chk(pending_out, 17'h0_0021);
		drain();
	endtask
	function automatic logic [15:0] exp_vec(input int i);
		if (i == 0) return 16'hfffe;
		if (i < 3) return 16'h0002;
		if (i < 5) return 16'hfffc - 16'(2 * (i - 3));
		if (i < 9) return 16'h0000;
		return 16'hfff8 - 16'(2 * (i - 9));
	endfunction
	task automatic t_ladder();
		for (int i = 0; i < 17; i++) begin
			pulse(17'h1_ffff << i);
			@(negedge mclk_in);
			chk(pending_out, 17'h1_ffff << i);
			chk({grant_valid_out, grant_source_out}, {1'b1, 5'(i)});
			chk(grant_priority_out, 17'((i == 0) ? 1 : (i < 3) ? 2 : i));
			chk(grant_vector_out, exp_vec(i));
			chk({grant_has_vector_out, emulator_entry_out}, {i < 5 || i > 8, i == 1 || i == 2});
			drain();
		end
	endtask
	task automatic t_hold();
		pulse(17'h1_0000);
		pulse(17'h0_0008);
		chk({grant_valid_out, grant_source_out}, {1'b1, 5'd16});
		chk(pending_out, 17'h1_0008);
		@(negedge mclk_in) grant_ack_in = 1'b1;
		@(negedge mclk_in) grant_ack_in = 1'b0;
		@(negedge mclk_in);
		chk({grant_valid_out, grant_source_out}, {1'b1, 5'd3});
		drain();
	endtask
	task automatic t_download();
		@(negedge mclk_in) download_active_in = 1'b1;
		pulse(17'h1_0006);
		chk(pending_out, 17'h0_0000);
		chk(grant_valid_out, 1'b0);
		pulse(17'h1_0001);
		@(negedge mclk_in);
		chk({grant_valid_out, grant_source_out}, {1'b1, 5'd0});
		chk(pending_out, 17'h0_0001);
		@(negedge mclk_in) download_active_in = 1'b0;
		drain();
	endtask
	initial begin
		repeat (20) @(posedge mclk_in);
		@(negedge mclk_in) sys_rst_in = 1'b0;
		t_sysreset();
		t_ladder();
		t_hold();
		t_preempt();
		t_download();
		close_out();
	end
	initial begin
		#200000;
		err_total++;
		close_out();
	end
endmodule
